// ---- src/lfs_pkg.sv ----
// Package for the LED driver fault supervisor: timing counts, structs, states.
// Assumes a single 200 MHz core clock; comparator inputs arrive as raw levels.
package lfs_pkg;

	localparam int CLK_MHZ = 200;
	localparam int OTP_BLANK_US = 250;
	localparam int SD_CONFIRM_NS = 30000;
	localparam int SHORT_MS = 90;
	localparam int BO_BLANK_MS = 25;
	localparam int RECOVERY_MS = 4000;
	localparam int PEAK2_CYCLES = 4;

	// Least times rounded up, all exact at 200 MHz
	localparam int OTP_BLANK_CYC = OTP_BLANK_US * CLK_MHZ;
	localparam int SD_CONFIRM_CYC = (SD_CONFIRM_NS * CLK_MHZ + 999) / 1000;
	localparam int SHORT_CYC = SHORT_MS * 1000 * CLK_MHZ;
	localparam int BO_BLANK_CYC = BO_BLANK_MS * 1000 * CLK_MHZ;
	localparam int RECOVERY_CYC = RECOVERY_MS * 1000 * CLK_MHZ;

	localparam int TMR_W = 30;
	localparam int REF_W = 8;
	localparam logic [REF_W-1:0] REF_FULL = 8'hff;
	localparam logic [REF_W-1:0] REF_HALF = 8'h80;
	localparam logic [REF_W-1:0] REF_ZERO = 8'h00;
	localparam logic [2:0] PEAK2_LAST = 3'h4;

	// Digitised comparator results
	typedef struct packed {
		logic over_temp;
		logic temp_shutdown;
		logic sd_overvoltage;
		logic overvoltage_trip;
		logic line_good_level;
		logic line_lost_level;
		logic peak_limit_level;
		logic peak_double_level;
		logic setpoint_reached;
		logic valley_above_short;
		logic cs_pin_fault;
		logic light_off_level;
		logic light_full_level;
		logic thermal_foldback;
		logic foldback_floor;
	} lfs_sense_t;

	typedef enum logic [2:0] {
		LFS_OFF,
		LFS_RUN,
		LFS_HALT,
		LFS_WAIT_LINE
	} lfs_state_t;

endpackage

// ---- src/lfs_supervisor.sv ----
// LED driver fault supervisor: gate control, fault halts, auto-recovery, reference.
// Assumes comparators arrive unsynchronised; vcc_ok_i low means undervoltage.
`timescale 1ns/1ps
module lfs_supervisor
	import lfs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic vcc_ok_i,
	input wire lfs_sense_t sense_i,
	input wire logic valley_clock_i,
	input wire logic line_change_i,
	input wire logic [REF_W-1:0] foldback_ref_i,
	input wire logic [REF_W-1:0] light_level_ref_i,
	input wire logic [3:0] valley_request_i,
	output logic gate_o,
	output logic comp_ground_o,
	output logic fault_halt_o,
	output logic running_o,
	output logic [REF_W-1:0] active_current_reference_o,
	output logic [3:0] valley_lock_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int SW = $bits(lfs_sense_t) + 3;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {sense_i, vcc_ok_i, valley_clock_i, line_change_i};
			sync2 <= sync1;
		end
	end
	lfs_sense_t s;
	logic vcc_ok;
	logic vclk;
	logic line_chg;
	assign {s, vcc_ok, vclk, line_chg} = sync2;

	// ----------------------------------------
	// State and counters
	// ----------------------------------------
	lfs_state_t state, next_state;
	logic [TMR_W-1:0] blank_cnt, next_blank_cnt;
	logic [TMR_W-1:0] sd_cnt, next_sd_cnt;
	logic [TMR_W-1:0] short_cnt, next_short_cnt;
	logic [TMR_W-1:0] bo_cnt, next_bo_cnt;
	logic [TMR_W-1:0] rec_cnt, next_rec_cnt;
	logic [2:0] peak2_cnt, next_peak2_cnt;
	logic peak2_seen, next_peak2_seen;
	logic gate, next_gate;
	logic comp_gnd, next_comp_gnd;
	logic [REF_W-1:0] ref_q, next_ref_q;
	logic [3:0] valley, next_valley;
	logic vclk_d;
	logic fault_now;
	logic sd_fault;
	logic otp_blanked;
	logic gate_kill;

	always_comb begin
		otp_blanked = (blank_cnt < TMR_W'(OTP_BLANK_CYC));
		sd_fault = s.sd_overvoltage || (s.over_temp && !otp_blanked);
		gate_kill = s.peak_limit_level || s.setpoint_reached
			|| s.light_off_level;
		fault_now = (sd_cnt >= TMR_W'(SD_CONFIRM_CYC))
			|| (peak2_cnt >= PEAK2_LAST)
			|| (short_cnt >= TMR_W'(SHORT_CYC))
			|| s.overvoltage_trip
			|| s.temp_shutdown
			|| s.cs_pin_fault;
	end

	always_comb begin
		next_state = state;
		next_blank_cnt = blank_cnt;
		next_sd_cnt = '0;
		next_short_cnt = '0;
		next_bo_cnt = '0;
		next_rec_cnt = '0;
		next_peak2_cnt = peak2_cnt;
		next_peak2_seen = peak2_seen;
		next_gate = 1'b0;
		next_comp_gnd = comp_gnd;
		case (state)
			LFS_OFF: begin
				next_blank_cnt = '0;
				if (vcc_ok) begin
					next_state = LFS_WAIT_LINE;
				end
			end
			LFS_WAIT_LINE: begin
				if (!otp_blanked) begin
					next_blank_cnt = blank_cnt;
				end else begin
					next_blank_cnt = blank_cnt + TMR_W'(1);
				end
				if (s.line_good_level) begin
					next_state = LFS_RUN;
					next_comp_gnd = 1'b0;
					next_peak2_cnt = '0;
				end
			end
			LFS_RUN: begin
				if (otp_blanked) begin
					next_blank_cnt = blank_cnt + TMR_W'(1);
				end
				next_sd_cnt = sd_fault ? sd_cnt + TMR_W'(1) : '0;
				next_short_cnt = s.valley_above_short ? '0 : short_cnt + TMR_W'(1);
				next_bo_cnt = s.line_lost_level ? bo_cnt + TMR_W'(1) : '0;
				// Count a double-peak cycle at each on-time end; a clean cycle restarts it
				if (s.peak_double_level) begin
					next_peak2_seen = 1'b1;
				end
				if (gate && gate_kill) begin
					next_peak2_cnt = (peak2_seen || s.peak_double_level) ? peak2_cnt + 3'h1 : '0;
					next_peak2_seen = 1'b0;
				end
				next_gate = gate ? !gate_kill : (vclk && !vclk_d && !gate_kill);
				if (fault_now) begin
					next_state = LFS_HALT;
					next_gate = 1'b0;
					next_comp_gnd = 1'b1;
				end else if (bo_cnt >= TMR_W'(BO_BLANK_CYC)) begin
					next_state = LFS_WAIT_LINE;
					next_gate = 1'b0;
				end
			end
			LFS_HALT: begin
				// New faults ignored until the timer ends
				next_rec_cnt = rec_cnt + TMR_W'(1);
				if (rec_cnt >= TMR_W'(RECOVERY_CYC - 1)) begin
					next_state = LFS_WAIT_LINE;
					next_blank_cnt = '0;
					next_peak2_cnt = '0;
					next_peak2_seen = 1'b0;
				end
			end
			default: begin
				next_state = LFS_OFF;
			end
		endcase
		// Undervoltage resets without grounding the averaging node
		if (!vcc_ok) begin
			next_state = LFS_OFF;
			next_gate = 1'b0;
		end
	end

	// ----------------------------------------
	// Reference and valley lock
	// ----------------------------------------
	always_comb begin
		next_ref_q = REF_FULL;
		if (s.light_off_level) begin
			next_ref_q = REF_ZERO;
		end else if (!s.light_full_level) begin
			next_ref_q = light_level_ref_i;
		end
		if (s.thermal_foldback) begin
			// Floor keeps foldback from going under half
			if (s.foldback_floor || foldback_ref_i < REF_HALF) begin
				next_ref_q = (next_ref_q < REF_HALF) ? next_ref_q : REF_HALF;
			end else if (foldback_ref_i < next_ref_q) begin
				next_ref_q = foldback_ref_i;
			end
		end
		// Lock avoids valley hopping, hence audible noise
		next_valley = valley;
		if (line_chg || ref_q != next_ref_q || state != LFS_RUN) begin
			next_valley = valley_request_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= LFS_OFF;
			blank_cnt <= '0;
			sd_cnt <= '0;
			short_cnt <= '0;
			bo_cnt <= '0;
			rec_cnt <= '0;
			peak2_cnt <= '0;
			peak2_seen <= 1'b0;
			gate <= 1'b0;
			comp_gnd <= 1'b1;
			ref_q <= REF_ZERO;
			valley <= 4'h1;
			vclk_d <= 1'b0;
			fault_halt_o <= 1'b0;
			running_o <= 1'b0;
		end else begin
			state <= next_state;
			blank_cnt <= next_blank_cnt;
			sd_cnt <= next_sd_cnt;
			short_cnt <= next_short_cnt;
			bo_cnt <= next_bo_cnt;
			rec_cnt <= next_rec_cnt;
			peak2_cnt <= next_peak2_cnt;
			peak2_seen <= next_peak2_seen;
			gate <= next_gate;
			comp_gnd <= next_comp_gnd;
			ref_q <= next_ref_q;
			valley <= next_valley;
			vclk_d <= vclk;
			fault_halt_o <= (next_state == LFS_HALT);
			running_o <= (next_state == LFS_RUN);
		end
	end

	// Gate output is the flop; next_gate already holds the kill term
	assign gate_o = gate;
	assign comp_ground_o = comp_gnd;
	assign active_current_reference_o = ref_q;
	assign valley_lock_o = valley;

endmodule

// ---- test/lfs_stage.sv ----
// Power stage model: valley ticks, current sense after on-time.
// Assumes the bench clock; slow_i gives a longer on-time.
`timescale 1ns/1ps
module lfs_stage (
	input wire logic clk_i,
	input wire logic gate_i,
	input wire logic slow_i,
	output logic valley_o,
	output logic sense_o
);
// ---
// Model
// ---
int on_cnt = 0;
int tick = 0;
initial begin
	valley_o = 1'b0;
	sense_o = 1'b0;
end
always @(negedge clk_i) begin
	tick <= tick + 1;
	on_cnt <= gate_i ? on_cnt + 1 : 0;
	valley_o <= (tick % 16) < 2;
	// Current only ramps while the switch is on
	sense_o <= on_cnt >= (slow_i ? 12 : 3);
end
endmodule

// ---- test/lfs_checker.sv ----
// Port checker for the fault supervisor, bound at the foot.
// Assumes the two-flop input sync of the supervisor.
`timescale 1ns/1ps
module lfs_checker import lfs_pkg::*; (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic vcc_ok_i,
	input wire lfs_sense_t sense_i,
	input wire logic gate_o,
	input wire logic comp_ground_o,
	input wire logic fault_halt_o,
	input wire logic running_o,
	input wire logic [REF_W-1:0] active_current_reference_o
);
// ---
// Properties
// ---
default clocking @(posedge core_clk_i); endclocking
default disable iff (!arst_n_i);
a_peak_gate_off: assert property (sense_i.peak_limit_level [*3] |=> !gate_o)
	else $error("gate high past peak");
a_setpoint_gate_off: assert property (sense_i.setpoint_reached [*3] |=> !gate_o)
	else $error("gate high past setpoint");
a_dim_gate_off: assert property (sense_i.light_off_level [*3] |=> !gate_o)
	else $error("gate high while dim off");
a_dim_ref_zero: assert property (sense_i.light_off_level [*4] |=>
	active_current_reference_o == REF_ZERO) else $error("reference not zero");
a_halt_gate_low: assert property (fault_halt_o |-> !gate_o && !running_o)
	else $error("switching during halt");
a_halt_comp_ground: assert property (fault_halt_o |-> comp_ground_o)
	else $error("node not grounded");
a_halt_hold: assert property ($rose(fault_halt_o) |=> fault_halt_o [*8])
	else $error("halt ended early");
a_uv_no_run: assert property (!vcc_ok_i [*3] |=> !running_o)
	else $error("running on undervoltage");
c_halt: cover property ($rose(fault_halt_o));
c_gate: cover property ($rose(gate_o));
c_half: cover property (active_current_reference_o == REF_HALF);
endmodule
bind lfs_supervisor lfs_checker u_lfs_checker (.core_clk_i, .arst_n_i, .vcc_ok_i, .sense_i,
	.gate_o, .comp_ground_o, .fault_halt_o, .running_o, .active_current_reference_o);

// ---- test/lfs_supervisor_bench.sv ----
// Bench for the fault supervisor: reference table, then fault cases.
// Assumes lfs_stage as power stage; long halts are never waited out.
`timescale 1ns/1ps
module lfs_supervisor_bench import lfs_pkg::*; ();
// ---
// Bench
// ---
typedef struct packed {
	logic [3:0] mode;
	logic [7:0] fb, lv, ex;
} lfs_row_t;
logic clk = 0, rst_n = 0, vcc = 0, slow = 0;
logic gate_o, comp_ground_o, fault_halt_o, running_o, vc, pk;
logic [7:0] fb = 8'h00, lv = 8'h00, ref_o;
logic [3:0] vreq = 4'h3, vl;
lfs_sense_t s = '0, sn;
int bad_count = 0, cmp_count = 0;
// Mode: off, full, foldback, floor
lfs_row_t rows [5] = '{28'h8000000, 28'h40000ff, 28'h6c000c0, 28'h7100080, 28'h0005a5a};
initial forever #2.5 clk = ~clk;
always_comb begin
	sn = s;
	sn.setpoint_reached = s.setpoint_reached | pk;
end
lfs_supervisor u_lfs_supervisor (.core_clk_i(clk), .arst_n_i(rst_n), .vcc_ok_i(vcc),
	.sense_i(sn), .valley_clock_i(vc), .line_change_i(1'b0), .foldback_ref_i(fb),
	.light_level_ref_i(lv), .valley_request_i(vreq), .gate_o, .comp_ground_o, .fault_halt_o,
	.running_o, .active_current_reference_o(ref_o), .valley_lock_o(vl));
lfs_stage u_lfs_stage (.clk_i(clk), .gate_i(gate_o), .slow_i(slow), .valley_o(vc), .sense_o(pk));
function logic pick(int w);
	case (w)
		0: return running_o;
		1: return gate_o;
		2: return !gate_o;
		default: return fault_halt_o;
	endcase
endfunction
task chk8(input logic [7:0] g, input logic [7:0] e);
	cmp_count++;
	if (g !== e) begin
		bad_count++;
		$display("Error t=%0t got %h exp %h", $time, g, e);
	end
endtask
task chk1(input logic g, input logic e);
	chk8({7'h0, g}, {7'h0, e});
endtask
task complete_run();
	$display("%0d compares, %0d mismatches", cmp_count, bad_count);
	if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
// Bounded wait; a timeout ends the run
task wt(int w, int n);
	repeat (n) if (pick(w) !== 1'b1) @(negedge clk);
	chk1(pick(w), 1'b1);
	if (pick(w) !== 1'b1) complete_run();
endtask
task low(int n);
	repeat (4) @(negedge clk);
	repeat (n) begin
		@(negedge clk);
		chk1(gate_o, 1'b0);
	end
endtask
task apply(lfs_row_t r);
	{s.light_off_level, s.light_full_level, s.thermal_foldback, s.foldback_floor} = r.mode;
	fb = r.fb;
	lv = r.lv;
endtask
task start(lfs_sense_t x);
	rst_n = 0;
	vcc = 0;
	s = x;
	repeat (12) @(negedge clk);
	chk1(gate_o, 1'b0);
	chk1(comp_ground_o, 1'b1);
	chk8(ref_o, 8'h00);
	rst_n = 1;
	repeat (3) @(negedge clk);
	vcc = 1;
	s.line_good_level = 1;
	s.valley_above_short = 1;
	s.light_full_level = 1;
	wt(0, 20);
	$display("start-up done");
endtask
initial begin
	start('0);
	wt(1, 100);
	chk8({4'h0, vl}, 8'h03);
	vreq = 4'h5;
	repeat (4) @(negedge clk);
	chk8({4'h0, vl}, 8'h03);
	wt(2, 40);
	s.peak_limit_level = 1;
	low(40);
	s.peak_limit_level = 0;
	foreach (rows[i]) begin
		apply(rows[i]);
		repeat (8) @(negedge clk);
		chk8(ref_o, rows[i].ex);
	end
	chk8({4'h0, vl}, 8'h05);
	apply(rows[0]);
	low(100);
	apply(rows[1]);
	s.sd_overvoltage = 1;
	repeat (5900) @(negedge clk);
	chk1(fault_halt_o, 1'b0);
	wt(3, 300);
	chk1(comp_ground_o, 1'b1);
	low(50);
	$display("gate and reference tests done");
	// Over-temperature from the first edge
	start(15'h4000);
	repeat (49000) @(negedge clk);
	chk1(fault_halt_o, 1'b0);
	wt(3, 8000);
	slow = 1;
	// Double peak on every on-time
	start(15'h0080);
	wt(3, 800);
	$display("fault tests done");
	complete_run();
end
endmodule
